// ### inc/ptu_pkg.sv
// shared constants, register map and carrier types of the periodic tick unit
package ptu_pkg;

  // ==========================================================
  // widths
  localparam int unsigned PRESC_W = 15;          // shared prescaler counter
  localparam int unsigned PERIOD_W = 4;          // period select field
  localparam int unsigned LEVEL_N = 8;           // level events, div 64 .. div 8192
  localparam int unsigned LEVEL_LSB = 5;         // prescaler bit of the div 64 level
  localparam int unsigned IRQ_N = 3;             // tick, overflow, compare
  localparam int unsigned ADDR_W = 8;            // decoded byte address bits

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_COUNTER_CTRL = 8'h00;  // counter_enable
  localparam logic [ADDR_W-1:0] OFF_TICK_CONTROL = 8'h10;  // tick_control
  localparam logic [ADDR_W-1:0] OFF_TICK_SYNC_STATUS = 8'h14;  // busy flags
  localparam logic [ADDR_W-1:0] OFF_TICK_IRQ_ENABLE = 8'h18;  // mask register
  localparam logic [ADDR_W-1:0] OFF_IRQ_FLAGS = 8'h1c;   // sticky status
  localparam logic [ADDR_W-1:0] OFF_PRESC_VALUE = 8'h20;  // prescaler readback

  // ==========================================================
  // field positions
  localparam int unsigned CTL_EN_BIT = 0;        // tick_enable / counter_enable
  localparam int unsigned CTL_PER_LSB = 3;       // period field in tick_control
  localparam int unsigned ST_CTL_BUSY_BIT = 0;   // control_sync_busy
  localparam int unsigned ST_CNT_BUSY_BIT = 1;   // counter enable still crossing
  localparam int unsigned IRQ_TICK_BIT = 0;      // tick_irq_bit
  localparam int unsigned IRQ_OVF_BIT = 1;       // overflow flag
  localparam int unsigned IRQ_CMP_BIT = 2;       // compare flag

  // ==========================================================
  // period codes: code k selects prescaler bit k, division 2^(k+1)
  localparam logic [PERIOD_W-1:0] PERIOD_OFF = 4'h0;   // no tick output
  localparam logic [PERIOD_W-1:0] PERIOD_MIN = 4'h1;   // divide by 4
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 4'he;   // divide by 32768
  localparam logic [PERIOD_W-1:0] DIV_SIXTEEN_SETTING = 4'h3;  // follows bit 3

  // ==========================================================
  // reset values
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 4'h0;
  localparam logic [IRQ_N-1:0] IRQ_RST = 3'h0;
  localparam logic [PRESC_W-1:0] PRESC_RST = 15'h0000;

  // ==========================================================
  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // event bundle toward the event system
  typedef struct packed {
    logic [LEVEL_N-1:0] level;   // tick_level_div_min .. tick_level_div_max
    logic overflow_event;        // one slow period pulse
    logic compare_match_event;   // one slow period pulse
    logic tick;                  // periodic tick output
  } ptu_evt_s;

endpackage : ptu_pkg

// ### design/ptu_sync.sv
// three-stage synchroniser for the slow clock pin with agreement filter
`timescale 1ns/10ps
module ptu_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic din,
  output logic level,
  output logic rise
);
  import ptu_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic s1;     // first stage, read only by s2
    logic s2;
    logic s3;
    logic filt;   // accepted level
  } ptu_sync_s;

  ptu_sync_s st;
  ptu_sync_s next_st;

  // next state: accept a change once stage two and three agree
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.filt = st.s3;
    end
  end

  // register with clock enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign level = st.filt;
  // strobe in the cycle before the accepted level goes high
  assign rise = st.s2 & st.s3 & ~st.filt;

endmodule : ptu_sync

// ### design/ptu_prescaler.sv
// shared prescaler counter with level event taps
`timescale 1ns/10ps
module ptu_prescaler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic slow_edge,
  input wire logic run,
  output logic [ptu_pkg::PRESC_W-1:0] count,
  output logic [ptu_pkg::LEVEL_N-1:0] level
);
  import ptu_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [PRESC_W-1:0] cnt;   // keeps its phase while stopped
  } ptu_presc_s;

  ptu_presc_s st;
  ptu_presc_s next_st;

  // count one per slow clock edge while either function runs
  always_comb begin
    next_st = st;
    if (run && slow_edge) begin
      next_st.cnt = st.cnt + 1'b1;   // R05
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st.cnt <= PRESC_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign count = st.cnt;

  // level taps div 64 .. div 8192, straight from counter flops
  genvar gi;
  generate
    for (gi = 0; gi < LEVEL_N; gi++) begin : g_lvl
      assign level[gi] = st.cnt[LEVEL_LSB+gi];   // R11
    end
  endgenerate

endmodule : ptu_prescaler

// ### design/ptu_top.sv
// periodic tick unit: shared prescaler, tick interrupt, events, ahb-lite slave
//
// Behaviour
// R01: software sets clock, irq enable, period, then enables
// R02: software polls busy flags before every write
// R03: tick_enable written 1 starts, 0 stops
// R04: tick and counter share one prescaler counter
// R05: prescaler stopped only when both enables low
// R06: first tick anywhere within one period
// R07: tick toggles every half selected period
// R08: tick output equals selected prescaler bit
// R09: overflow and compare events last one slow period
// R10: events fire exactly when their flags set
// R11: level events at divisions 64 to 8192
// R12: period selects division 4 up to 32768
// R13: irq high while enabled flag is set
// R14: control busy while tick_control write crosses
// R15: tick flag set on tick rising edge
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module ptu_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // slow real-time clock pin
  input wire logic rtc_clk_pin,
  // counter conditions from the counter logic, same clock, one cycle each
  input wire logic overflow_cond,
  input wire logic compare_cond,
  // outputs
  output ptu_pkg::ptu_evt_s events,
  output logic counter_tick_run,
  output logic [ptu_pkg::PRESC_W-1:0] presc_count,
  output logic irq
);
  import ptu_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic tick_enable;                   // applied in slow domain
    logic [PERIOD_W-1:0] period;         // applied period code
    logic counter_enable;                // applied counter enable
    logic ctl_busy;                      // control_sync_busy
    logic [PERIOD_W:0] ctl_pend;         // pending {period, enable}
    logic cnt_busy;                      // counter enable crossing
    logic cnt_pend;                      // pending counter enable
    logic [IRQ_N-1:0] irq_en;            // tick_irq_enable_reg
    logic [IRQ_N-1:0] irq_flags;         // sticky status
    logic tick_q;                        // previous tick output
    logic ovf_pend;                      // overflow seen, waits for slow edge
    logic cmp_pend;                      // compare seen, waits for slow edge
    logic ovf_evt;                       // overflow_event level
    logic cmp_evt;                       // compare_match_event level
    logic wr_act;                        // write data phase pending
    logic [ADDR_W-1:0] wr_addr;          // address of that write
    logic [31:0] rdata;                  // read data register
  } ptu_top_s;

  ptu_top_s st;
  ptu_top_s next_st;

  // ==========================================================
  // helpers
  logic slow_edge;                       // rising edge of slow clock
  logic slow_level;
  logic [PRESC_W-1:0] cnt;
  logic [LEVEL_N-1:0] lvl;
  logic tick_out;
  logic addr_ok;
  logic rd_req;
  logic wr_req;
  logic [ADDR_W-1:0] a_addr;
  logic [IRQ_N-1:0] set_v;

  // register hit test, used by read and write decode
  function automatic logic ptu_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    ptu_hit = (a == off);
  endfunction : ptu_hit

  // tick bit select, zero for codes outside the legal range
  function automatic logic ptu_tick_bit(input logic [PRESC_W-1:0] c,
                                        input logic [PERIOD_W-1:0] p);
    if ((p >= PERIOD_MIN) && (p <= PERIOD_MAX)) begin
      ptu_tick_bit = c[p];   // R12
    end else begin
      ptu_tick_bit = 1'b0;
    end
  endfunction : ptu_tick_bit

  // ==========================================================
  // slow clock pin synchroniser
  ptu_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .din(rtc_clk_pin),
    .level(slow_level),
    .rise(slow_edge)
  );

  // shared prescaler, runs while either function is enabled
  ptu_prescaler u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .slow_edge(slow_edge),
    .run(st.tick_enable | st.counter_enable),  // R04 R05
    .count(cnt),
    .level(lvl)
  );

  // ==========================================================
  // bus decode
  assign a_addr = haddr[ADDR_W-1:0];
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign rd_req = addr_ok && !hwrite;
  assign wr_req = addr_ok && hwrite;

  // tick output follows the selected prescaler bit while enabled
  assign tick_out = st.tick_enable & ptu_tick_bit(cnt, st.period);  // R07 R08 R06

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    set_v = '0;

    // address phase: capture write, build read data
    next_st.wr_act = wr_req;
    next_st.wr_addr = a_addr;
    if (rd_req) begin
      next_st.rdata = '0;
      unique case (1'b1)
        ptu_hit(a_addr, OFF_COUNTER_CTRL): begin
          next_st.rdata[CTL_EN_BIT] = st.cnt_busy ? st.cnt_pend : st.counter_enable;
        end
        ptu_hit(a_addr, OFF_TICK_CONTROL): begin
          next_st.rdata[CTL_PER_LSB +: PERIOD_W+1] = '0;
          next_st.rdata[CTL_EN_BIT] = st.ctl_busy ? st.ctl_pend[0] : st.tick_enable;
          next_st.rdata[CTL_PER_LSB +: PERIOD_W] =
            st.ctl_busy ? st.ctl_pend[PERIOD_W:1] : st.period;
        end
        ptu_hit(a_addr, OFF_TICK_SYNC_STATUS): begin
          next_st.rdata[ST_CTL_BUSY_BIT] = st.ctl_busy;   // R14
          next_st.rdata[ST_CNT_BUSY_BIT] = st.cnt_busy;
        end
        ptu_hit(a_addr, OFF_TICK_IRQ_ENABLE): begin
          next_st.rdata[IRQ_N-1:0] = st.irq_en;
        end
        ptu_hit(a_addr, OFF_IRQ_FLAGS): begin
          next_st.rdata[IRQ_N-1:0] = st.irq_flags;
        end
        ptu_hit(a_addr, OFF_PRESC_VALUE): begin
          next_st.rdata[PRESC_W-1:0] = cnt;
        end
        default: begin
          next_st.rdata = '0;   // unmapped reads as zero
        end
      endcase
    end

    // read of the status register clears it
    if (rd_req && ptu_hit(a_addr, OFF_IRQ_FLAGS)) begin
      next_st.irq_flags = '0;
    end

    // data phase: apply write
    if (st.wr_act) begin
      unique case (1'b1)
        ptu_hit(st.wr_addr, OFF_COUNTER_CTRL): begin
          if (!st.cnt_busy) begin
            next_st.cnt_pend = hwdata[CTL_EN_BIT];
            next_st.cnt_busy = 1'b1;
          end
        end
        ptu_hit(st.wr_addr, OFF_TICK_CONTROL): begin
          if (!st.ctl_busy) begin   // R02
            next_st.ctl_pend = {hwdata[CTL_PER_LSB +: PERIOD_W], hwdata[CTL_EN_BIT]};
            next_st.ctl_busy = 1'b1;   // R14
          end
        end
        ptu_hit(st.wr_addr, OFF_TICK_IRQ_ENABLE): begin
          next_st.irq_en = hwdata[IRQ_N-1:0];
        end
        ptu_hit(st.wr_addr, OFF_IRQ_FLAGS): begin
          next_st.irq_flags = st.irq_flags & ~hwdata[IRQ_N-1:0];   // R15
        end
        default: begin
          next_st.wr_act = next_st.wr_act;   // ignored write
        end
      endcase
    end

    // counter conditions wait for the next slow edge
    if (overflow_cond) begin
      next_st.ovf_pend = 1'b1;
    end
    if (compare_cond) begin
      next_st.cmp_pend = 1'b1;
    end

    // slow domain work on each slow clock edge
    if (slow_edge) begin
      // pending control writes take effect here
      if (st.ctl_busy) begin
        next_st.tick_enable = st.ctl_pend[0];            // R03
        next_st.period = st.ctl_pend[PERIOD_W:1];
        next_st.ctl_busy = 1'b0;                         // R14
      end
      if (st.cnt_busy) begin
        next_st.counter_enable = st.cnt_pend;
        next_st.cnt_busy = 1'b0;
      end
      // events last from this edge to the next
      next_st.ovf_evt = st.ovf_pend | overflow_cond;     // R09
      next_st.cmp_evt = st.cmp_pend | compare_cond;      // R09
      next_st.ovf_pend = 1'b0;
      next_st.cmp_pend = 1'b0;
      set_v[IRQ_OVF_BIT] = st.ovf_pend | overflow_cond;  // R10
      set_v[IRQ_CMP_BIT] = st.cmp_pend | compare_cond;   // R10
    end

    // tick flag on rising edge of the tick output
    next_st.tick_q = tick_out;
    set_v[IRQ_TICK_BIT] = tick_out & ~st.tick_q;         // R15

    // set wins over any clear in the same cycle
    next_st.irq_flags = next_st.irq_flags | set_v;
  end

  // ==========================================================
  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.period <= PERIOD_RST;
      st.irq_en <= IRQ_RST;
      st.irq_flags <= IRQ_RST;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout = 1'b1;            // zero wait states
  assign hresp = 1'b0;                // always okay
  assign hrdata = st.rdata;
  assign events.level = lvl;          // R11
  assign events.overflow_event = st.ovf_evt;
  assign events.compare_match_event = st.cmp_evt;
  assign events.tick = tick_out;
  assign counter_tick_run = st.counter_enable;
  assign presc_count = cnt;
  assign irq = |(st.irq_flags & st.irq_en);   // R13

  // ==========================================================
  // assertions
  AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(st.irq_flags & st.irq_en)) else $error("irq not flag and enable"); // R13

  AST_PRESC_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !st.tick_enable && !st.counter_enable) |=> $stable(cnt))
    else $error("prescaler moved while stopped"); // R05

  AST_PRESC_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && slow_edge && (st.tick_enable || st.counter_enable)) |=>
    (cnt == $past(cnt) + 1'b1)) else $error("prescaler did not count"); // R04

  AST_TICK_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.tick_enable && st.period == DIV_SIXTEEN_SETTING) |-> (tick_out == cnt[3]))
    else $error("tick not bit three"); // R08

  AST_TICK_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    !st.tick_enable |-> !tick_out) else $error("tick while disabled"); // R03

  AST_BUSY_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && st.wr_act && st.wr_addr == OFF_TICK_CONTROL && !st.ctl_busy) |=> st.ctl_busy)
    else $error("busy not raised on write"); // R14

  AST_BUSY_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && slow_edge && st.ctl_busy) |=> (!st.ctl_busy && st.tick_enable == $past(st.ctl_pend[0])))
    else $error("control not applied at slow edge"); // R03

  AST_TICK_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && $rose(tick_out)) |-> ##1 st.irq_flags[IRQ_TICK_BIT])
    else $error("tick flag missing"); // R15

  AST_OVF_EVT: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && slow_edge && (st.ovf_pend || overflow_cond)) |=>
    (events.overflow_event && st.irq_flags[IRQ_OVF_BIT]))
    else $error("overflow event and flag differ"); // R10

  AST_EVT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (!slow_edge || !ce) |=> $stable(events.compare_match_event))
    else $error("compare event changed off slow edge"); // R09

  AST_LVL: assert property (@(posedge hclk) disable iff (!hresetn)
    events.level[LEVEL_N-1] == cnt[LEVEL_LSB+LEVEL_N-1])
    else $error("div 8192 level wrong"); // R11

  COV_TICK: cover property (@(posedge hclk) disable iff (!hresetn) $rose(tick_out));
  COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  COV_OVF: cover property (@(posedge hclk) disable iff (!hresetn) $rose(events.overflow_event));
  COV_BUSY: cover property (@(posedge hclk) disable iff (!hresetn) $fell(st.ctl_busy));

endmodule : ptu_top

// ### testbench/ptu_partner.sv
// far side model: free-running slow clock source and event pulse meter
`timescale 1ns/10ps
module ptu_partner #(
  parameter int HALF_CYC = 12  // slow clock half period in hclk cycles
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire ptu_pkg::ptu_evt_s events,
  output logic rtc_clk_pin,
  output int ovf_len,
  output int cmp_len
);
  import ptu_pkg::*;

  int ovf_run;  // cycles the overflow pulse has lasted so far
  int cmp_run;  // same for the compare pulse

  // ==========================================================
  // slow clock: runs free, offset so its edges never meet hclk edges
  initial begin
    rtc_clk_pin = 1'b0;
    #3;
    forever #(HALF_CYC * 10) rtc_clk_pin = ~rtc_clk_pin;
  end

  // ==========================================================
  // event user: length of the last pulse in hclk cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_run <= 0;
      cmp_run <= 0;
      ovf_len <= 0;
      cmp_len <= 0;
    end else begin
      ovf_run <= events.overflow_event ? ovf_run + 1 : 0;
      cmp_run <= events.compare_match_event ? cmp_run + 1 : 0;
      // pulse just ended: publish its length
      if (!events.overflow_event && ovf_run != 0) ovf_len <= ovf_run;
      if (!events.compare_match_event && cmp_run != 0) cmp_len <= cmp_run;
    end
  end
endmodule : ptu_partner

// ### testbench/periodic_interrupt_timer_bench.sv
// self-checking bench of the periodic tick unit with its far side model
`timescale 1ns/10ps
module periodic_interrupt_timer_bench;
  import ptu_pkg::*;
  // ==========================================================
  // constants and signals
  localparam int HALF = 12;  // slow half period in hclk cycles
  localparam int SLOW = 2 * HALF;  // one slow period in hclk cycles
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, overflow_cond, compare_cond;
  logic counter_tick_run, irq, rtc_clk_pin;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [PRESC_W-1:0] presc_count;
  ptu_evt_s events;
  int ovf_len, cmp_len, cyc, cyc2;
  int error_cnt = 0;  // mismatches
  int num_checks = 0;  // comparisons made
  logic follow_on = 1'b0;  // tick watcher armed
  logic follow_en = 1'b0;  // tick expected enabled
  int follow_code = 0;  // period code under watch

  // ==========================================================
  // bus clock, 100 MHz
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  ptu_top DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rtc_clk_pin(rtc_clk_pin),
    .overflow_cond(overflow_cond), .compare_cond(compare_cond), .events(events),
    .counter_tick_run(counter_tick_run), .presc_count(presc_count), .irq(irq));
  ptu_partner #(.HALF_CYC(HALF)) u_partner (.hclk(hclk), .hresetn(hresetn), .events(events),
    .rtc_clk_pin(rtc_clk_pin), .ovf_len(ovf_len), .cmp_len(cmp_len));

  // ==========================================================
  // reporting
  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic fail(input string msg);
    error_cnt++;
    $display("ERROR at %0t: %s", $time, msg);
  endtask : fail
  task automatic hang(input string msg);
    fail(msg);
    final_report();
  endtask : hang
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) fail(msg);
  endtask : check

  // ==========================================================
  // ahb-lite single word transfer, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) hang("bus hung");
      // address taken: release it, present write data
      if (ph == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "response not okay");
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, 32'h0);
    check(rd, exp, msg);
  endtask : rdc
  // wait until both busy flags are clear
  task automatic poll_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_TICK_SYNC_STATUS, 32'h0);
      n++;
    end while (rd[1:0] !== 2'b00 && n < 40);
    if (n >= 40) hang("busy never cleared");
  endtask : poll_idle

  // ==========================================================
  // output watching helpers
  function automatic logic sig(input int s);
    if (s == 0) return events.tick;
    if (s == 1) return events.overflow_event;
    return events.compare_match_event;
  endfunction : sig
  task automatic wait_lvl(input int s, input logic val, input int bound, output int n);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (sig(s) !== val && n < bound);
    if (n >= bound) hang("output wait ran out");
  endtask : wait_lvl
  task automatic pulse(input int s);
    @(posedge hclk);
    if (s == 1) overflow_cond <= 1'b1;
    else compare_cond <= 1'b1;
    @(posedge hclk);
    overflow_cond <= 1'b0;
    compare_cond <= 1'b0;
  endtask : pulse
  function automatic logic exp_tick();
    if (!follow_en || follow_code < int'(PERIOD_MIN) || follow_code > int'(PERIOD_MAX))
      return 1'b0;
    return presc_count[follow_code];
  endfunction : exp_tick
  // continuous compare of level taps and tick output
  always @(negedge hclk) begin
    if (hresetn === 1'b1) begin
      check({24'h0, events.level}, {24'h0, presc_count[12:5]}, "level taps");
      if (follow_on) check({31'h0, events.tick}, {31'h0, exp_tick()}, "tick out");
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check({20'h0, irq, events}, 32'h0, "outputs after reset");
    rdc(OFF_TICK_CONTROL, 32'h0, "tick control reset");
    rdc(OFF_IRQ_FLAGS, 32'h0, "flags reset");
    bus(1'b1, 8'h3c, 32'hffff_ffff);
    rdc(8'h3c, 32'h0, "unmapped read");
    repeat (3 * SLOW) @(posedge hclk);
    check({17'h0, presc_count}, 32'h0, "prescaler ran while off");
  endtask : t_reset
  task automatic t_start();
    poll_idle();
    bus(1'b1, OFF_TICK_IRQ_ENABLE, 32'h1);
    poll_idle();
    bus(1'b1, OFF_TICK_CONTROL, {25'h0, DIV_SIXTEEN_SETTING, 3'h0});
    poll_idle();
    @(negedge rtc_clk_pin);
    bus(1'b1, OFF_TICK_CONTROL, {25'h0, DIV_SIXTEEN_SETTING, 3'h1});
    bus(1'b1, OFF_TICK_CONTROL, {25'h0, PERIOD_MAX, 3'h1});
    rdc(OFF_TICK_SYNC_STATUS, 32'h1, "control busy missing");
    poll_idle();
    rdc(OFF_TICK_CONTROL, 32'h19, "busy write not dropped");
    follow_code = 3;
    follow_en = 1'b1;
    follow_on = 1'b1;
    wait_lvl(0, 1'b1, 16 * SLOW + 8, cyc);
    repeat (2) @(negedge hclk);
    check({31'h0, irq}, 32'h1, "tick irq missing");
    // measure whole halves: start at a fall, time the low half then the high half
    wait_lvl(0, 1'b0, 16 * SLOW, cyc);
    wait_lvl(0, 1'b1, 16 * SLOW, cyc);
    wait_lvl(0, 1'b0, 16 * SLOW, cyc2);
    check(cyc, 8 * SLOW, "tick half period");
    check(cyc + cyc2, 16 * SLOW, "tick period");
    rdc(OFF_IRQ_FLAGS, 32'h1, "tick flag");
    @(negedge hclk);
    check({31'h0, irq}, 32'h0, "read did not clear");
    bus(1'b1, OFF_TICK_IRQ_ENABLE, 32'h0);
    wait_lvl(0, 1'b0, 16 * SLOW, cyc);
    wait_lvl(0, 1'b1, 16 * SLOW, cyc);
    repeat (2) @(negedge hclk);
    check({31'h0, irq}, 32'h0, "masked flag raised irq");
    bus(1'b1, OFF_IRQ_FLAGS, 32'h1);
    rdc(OFF_IRQ_FLAGS, 32'h0, "write one did not clear");
  endtask : t_start
  task automatic t_periods();
    logic [PRESC_W-1:0] held;
    for (int k = 0; k < 16; k++) begin
      follow_on = 1'b0;
      poll_idle();
      bus(1'b1, OFF_TICK_CONTROL, 32'(k * 8 + 1));
      poll_idle();
      follow_code = k;
      follow_on = 1'b1;
      repeat (4 * SLOW) @(posedge hclk);
    end
    follow_on = 1'b0;
    bus(1'b1, OFF_TICK_CONTROL, {25'h0, DIV_SIXTEEN_SETTING, 3'h0});
    poll_idle();
    follow_code = 3;
    follow_en = 1'b0;
    follow_on = 1'b1;
    held = presc_count;
    repeat (3 * SLOW) @(posedge hclk);
    check({17'h0, presc_count}, {17'h0, held}, "prescaler ran while off");
    bus(1'b1, OFF_COUNTER_CTRL, 32'h1);
    poll_idle();
    check({31'h0, counter_tick_run}, 32'h1, "counter not running");
    repeat (2 * SLOW) @(posedge hclk);
    check({31'h0, presc_count === held}, 32'h0, "prescaler held with counter on");
  endtask : t_periods
  task automatic t_events();
    // the period sweep left the tick flag set; this read also clears it
    rdc(OFF_IRQ_FLAGS, 32'h1, "tick flag from period sweep");
    bus(1'b1, OFF_TICK_IRQ_ENABLE, 32'h2);
    pulse(1);
    wait_lvl(1, 1'b1, 2 * SLOW + 8, cyc);
    check({31'h0, irq}, 32'h1, "overflow irq not with event");
    wait_lvl(1, 1'b0, 2 * SLOW, cyc);
    @(negedge hclk);
    check(ovf_len, SLOW, "overflow pulse length");
    rdc(OFF_IRQ_FLAGS, 32'h2, "overflow flag");
    pulse(2);
    wait_lvl(2, 1'b1, 2 * SLOW + 8, cyc);
    check({31'h0, irq}, 32'h0, "masked compare raised irq");
    wait_lvl(2, 1'b0, 2 * SLOW, cyc);
    @(negedge hclk);
    check(cmp_len, SLOW, "compare pulse length");
    rdc(OFF_IRQ_FLAGS, 32'h4, "compare flag");
  endtask : t_events

  // ==========================================================
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    overflow_cond = 1'b0;
    compare_cond = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_start();
    t_periods();
    t_events();
    final_report();
  end
endmodule : periodic_interrupt_timer_bench
